// ### core/file_op_unit.sv
// Decode and execution of complement, decrement and decrement-skip-if-zero
//
// How it works
// - Complement inverts addressed register bits.
// - Destination bit selects accumulator or register.
// - Decrement subtracts one from register.
// - Decrement-skip subtracts one, routed by destination.
// - Zero decrement-skip result discards next, runs no_operation.
`timescale 1ns/100ps
`default_nettype none
`include "cds_map.svh"

module file_op_unit
    import cds_pkg::*;
#(
    parameter int DATA_W = 8,
    parameter int FREG_W = 5
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Instruction from fetch
    input wire logic instr_valid,
    input wire logic [`OPC_W-1:0] instr_word,
    // File register read port (combinational, same clock)
    output logic [FREG_W-1:0] freg_addr,
    input wire logic [DATA_W-1:0] freg_rdata,
    // File register write port
    output logic freg_we,
    output logic [FREG_W-1:0] freg_waddr,
    output logic [DATA_W-1:0] freg_wdata,
    // Accumulator and status
    output logic [DATA_W-1:0] acc_out,
    output logic zero_flag,
    // Fetch control
    output logic discard_fetched,
    output logic busy
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic file_op_t decode_op(input logic [`OPC_W-1:0] w);
        case (w[`OPC_HI:`OPC_LO])
            `OPC_COMPLEMENT: decode_op = OP_COMPLEMENT;
            `OPC_DECREMENT: decode_op = OP_DECREMENT;
            `OPC_DEC_SKIP: decode_op = OP_DEC_SKIP;
            default: decode_op = OP_NONE;
        endcase
    endfunction

    exec_state_t state_reg, state_next;
    logic [DATA_W-1:0] acc_reg, acc_next;
    logic zero_reg, zero_next;
    logic we_reg, we_next;
    logic [FREG_W-1:0] waddr_reg, waddr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic discard_reg, discard_next;
    file_op_t op;
    logic [DATA_W-1:0] result;
    logic to_reg;
    logic take;

    assign op = decode_op(instr_word);
    assign to_reg = instr_word[`DEST_BIT];
    assign freg_addr = instr_word[`FREG_HI:`FREG_LO];
    // Discarded word must not execute, so no new op during the no_operation slot
    assign take = instr_valid && (state_reg == ST_EXECUTE) && (op != OP_NONE);

    // ------------------------------------------------------------
    // Datapath and next state
    // ------------------------------------------------------------
    // Operand read is same-cycle, write lands a cycle later:
    // the register file must forward for back-to-back use of one register
    always_comb begin
        result = '0;
        case (op)
            OP_COMPLEMENT: result = ~freg_rdata;
            OP_DECREMENT: result = freg_rdata - DATA_W'(1);
            OP_DEC_SKIP: result = freg_rdata - DATA_W'(1);
            default: result = '0;
        endcase
    end

    always_comb begin
        state_next = ST_EXECUTE;
        acc_next = acc_reg;
        zero_next = zero_reg;
        we_next = 1'b0;
        waddr_next = waddr_reg;
        wdata_next = wdata_reg;
        discard_next = 1'b0;
        if (take) begin
            if (to_reg) begin
                we_next = 1'b1;
                waddr_next = freg_addr;
                wdata_next = result;
            end else begin
                acc_next = result;
            end
            // Skip keeps status so a loop counter leaves the caller's flag intact
            if (op != OP_DEC_SKIP) begin
                zero_next = (result == '0);
            end
            if (op == OP_DEC_SKIP && result == '0) begin
                state_next = ST_NO_OPERATION;
                discard_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_EXECUTE;
            acc_reg <= `ACC_RESET;
            zero_reg <= `ZERO_RESET;
            we_reg <= 1'b0;
            waddr_reg <= '0;
            wdata_reg <= '0;
            discard_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            acc_reg <= acc_next;
            zero_reg <= zero_next;
            we_reg <= we_next;
            waddr_reg <= waddr_next;
            wdata_reg <= wdata_next;
            discard_reg <= discard_next;
        end
    end

    assign acc_out = acc_reg;
    assign zero_flag = zero_reg;
    assign freg_we = we_reg;
    assign freg_waddr = waddr_reg;
    assign freg_wdata = wdata_reg;
    assign discard_fetched = discard_reg;
    // State decode, not a flop copy, so it cannot drift from the stall
    assign busy = (state_reg == ST_NO_OPERATION);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_COMPLEMENT_TO_ACC: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_COMPLEMENT && !to_reg |=> acc_out == ~$past(freg_rdata))
        else $error("complement result wrong in accumulator");

    AST_DEST_REG_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && to_reg |=> freg_we && freg_waddr == $past(freg_addr) && $stable(acc_out))
        else $error("register destination not written");

    AST_DEST_ACC_NO_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && !to_reg |=> !freg_we)
        else $error("accumulator destination wrote register");

    AST_DECREMENT_VALUE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_DECREMENT && to_reg |=> freg_wdata == $past(freg_rdata) - 8'h01)
        else $error("decrement result wrong");

    AST_DEC_SKIP_VALUE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_DEC_SKIP && !to_reg |=> acc_out == $past(freg_rdata) - 8'h01)
        else $error("decrement-skip result wrong");

    AST_COMPLEMENT_TO_REG: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_COMPLEMENT && to_reg |=> freg_wdata == ~$past(freg_rdata))
        else $error("complement result wrong in register write");

    AST_DECREMENT_TO_ACC: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_DECREMENT && !to_reg |=> acc_out == $past(freg_rdata) - 8'h01)
        else $error("decrement result wrong in accumulator");

    AST_DEC_SKIP_TO_REG: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_DEC_SKIP && to_reg |=> freg_we && freg_wdata == $past(freg_rdata) - 8'h01)
        else $error("decrement-skip register write wrong");

    AST_IDLE_NO_WRITE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !take |=> !freg_we && $stable(acc_out))
        else $error("result written without a taken op");

    // ------------------------------------------------------------
    // Skip, stall and zero flag checks
    // ------------------------------------------------------------

    AST_SKIP_TWO_CYCLES: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_DEC_SKIP && freg_rdata == 8'h01
        |=> discard_fetched && busy ##1 !busy && !discard_fetched)
        else $error("skip did not take exactly two cycles");

    AST_NO_SKIP_NONZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_DEC_SKIP && freg_rdata != 8'h01 |=> !busy && !discard_fetched)
        else $error("skip taken on nonzero result");

    AST_BUSY_IGNORES: assert property (@(posedge clk_sys) disable iff (sys_rst)
        busy |=> !freg_we && !discard_fetched && !busy && $stable(acc_out) && $stable(zero_flag))
        else $error("word in the no_operation slot had an effect");

    AST_DISCARD_WITH_BUSY: assert property (@(posedge clk_sys) disable iff (sys_rst)
        discard_fetched == busy)
        else $error("discard pulse and stall slot disagree");

    AST_ZERO_FLAG: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op != OP_DEC_SKIP |=> zero_flag == ($past(result) == 8'h00))
        else $error("zero flag wrong");

    AST_SKIP_KEEPS_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_DEC_SKIP |=> $stable(zero_flag))
        else $error("decrement-skip changed zero flag");

    AST_ZERO_HELD_IDLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
        !take |=> $stable(zero_flag))
        else $error("zero flag changed without a taken op");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------

    COV_SKIP: cover property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_DEC_SKIP && freg_rdata == 8'h01);
    COV_COMPLEMENT_REG: cover property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_COMPLEMENT && to_reg);
    COV_DECREMENT_ZERO: cover property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_DECREMENT && freg_rdata == 8'h01);
    COV_SKIP_NONZERO: cover property (@(posedge clk_sys) disable iff (sys_rst)
        take && op == OP_DEC_SKIP && freg_rdata != 8'h01);
    COV_WORD_DROPPED: cover property (@(posedge clk_sys) disable iff (sys_rst)
        busy && instr_valid);

endmodule

`default_nettype wire

// ### dv/testbench.sv
// Self-checking bench for the file-register op unit
`timescale 1ns/100ps
`default_nettype none
`include "cds_map.svh"
module testbench;
import cds_pkg::*;
typedef struct packed {
    logic we; logic [4:0] wa; logic [7:0] wd; logic [7:0] acc; logic z; logic dis; logic busy;
} note_t;
logic clk_sys = 1'b0;
logic sys_rst = 1'b1;
logic instr_valid = 1'b0;
logic [11:0] instr_word = 12'h000;
logic [4:0] freg_addr, freg_waddr;
logic [7:0] freg_wdata, acc_out;
wire logic [7:0] freg_rdata;
logic freg_we, zero_flag, discard_fetched, busy;
logic [7:0] mem [32];
logic [7:0] mem_m [32];
logic [7:0] acc_m = 8'h00;
logic z_m = 1'b0;
logic busy_m = 1'b0;
note_t notes[$];
note_t got;
int n_mismatch = 0;
int n_tests = 0;
int seed = 73;
int k;
initial forever #25 clk_sys = ~clk_sys;
file_op_unit file_op_unit_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .instr_valid(instr_valid),
    .instr_word(instr_word), .freg_addr(freg_addr), .freg_rdata(freg_rdata),
    .freg_we(freg_we), .freg_waddr(freg_waddr), .freg_wdata(freg_wdata), .acc_out(acc_out),
    .zero_flag(zero_flag), .discard_fetched(discard_fetched), .busy(busy));
// Write-through so a back-to-back op sees the result still in flight
assign freg_rdata = (freg_we === 1'b1 && freg_waddr == freg_addr) ? freg_wdata : mem[freg_addr];
always @(posedge clk_sys) if (freg_we === 1'b1) mem[freg_waddr] <= freg_wdata;
task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
endtask
task test_done;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask
// ----------------------------------------
// Driver with reference model
// ----------------------------------------
task drive(input logic v, input logic [11:0] w);
    note_t n;
    logic [7:0] res;
    logic [5:0] op;
    @(posedge clk_sys); #2;
    instr_valid = v;
    instr_word = w;
    op = w[11:6];
    n = '0;
    if (busy_m) busy_m = 1'b0;
    else if (v && (op == `OPC_COMPLEMENT || op == `OPC_DECREMENT || op == `OPC_DEC_SKIP)) begin
        res = (op == `OPC_COMPLEMENT) ? ~mem_m[w[4:0]] : mem_m[w[4:0]] - 8'h01;
        if (w[5]) mem_m[w[4:0]] = res;
        else acc_m = res;
        n.we = w[5]; n.wa = w[4:0]; n.wd = res;
        if (op != `OPC_DEC_SKIP) z_m = (res == 8'h00);
        else if (res == 8'h00) begin
            busy_m = 1'b1; n.dis = 1'b1; n.busy = 1'b1;
        end
    end
    n.acc = acc_m; n.z = z_m;
    notes.push_back(n);
    #1 check({11'h0, freg_addr}, {11'h0, w[4:0]});
endtask
task reset_dut;
    @(posedge clk_sys); #2;
    sys_rst = 1'b1;
    instr_valid = 1'b0;
    repeat (6) @(posedge clk_sys);
    check({acc_out, zero_flag, busy, discard_fetched, freg_we}, 16'h0000);
    #2 sys_rst = 1'b0;
    acc_m = 8'h00; z_m = 1'b0; busy_m = 1'b0;
endtask
// ----------------------------------------
// Monitor
// ----------------------------------------
always @(posedge clk_sys) begin
    #1;
    if (notes.size() > 0) begin
        got = notes.pop_front();
        check({15'h0, freg_we}, {15'h0, got.we});
        if (got.we) check({3'h0, freg_waddr, freg_wdata}, {3'h0, got.wa, got.wd});
        check({8'h0, acc_out}, {8'h0, got.acc});
        check({15'h0, zero_flag}, {15'h0, got.z});
        check({14'h0, discard_fetched, busy}, {14'h0, got.dis, got.busy});
    end
end
initial begin
    #200000;
    n_mismatch++;
    test_done();
end
initial begin
    for (int i = 0; i < 32; i++) begin
        mem[i] = $random(seed); mem_m[i] = mem[i];
    end
    mem[3] = 8'h13; mem_m[3] = 8'h13; mem[7] = 8'h01; mem_m[7] = 8'h01;
    mem[5] = 8'h01; mem_m[5] = 8'h01;
    reset_dut();
    drive(1'b1, 12'h243);
    drive(1'b1, 12'h0E7);
    drive(1'b1, 12'h2E5);
    drive(1'b1, 12'h243); // Lost in the busy cycle
    drive(1'b1, 12'h2E5);
    drive(1'b1, 12'hFFF);
    drive(1'b0, 12'h243);
    for (int i = 0; i < 300; i++) begin
        k = $random(seed) & 3;
        drive(($random(seed) & 7) != 0, {(k == 0) ? `OPC_COMPLEMENT : (k == 1) ? `OPC_DECREMENT :
            (k == 2) ? `OPC_DEC_SKIP : 6'($random(seed)), 6'($random(seed))});
    end
    drive(1'b0, 12'h000);
    drive(1'b0, 12'h000);
    @(posedge clk_sys); #2;
    mem[9] = 8'h01; mem_m[9] = 8'h01;
    drive(1'b1, 12'h2E9);
    drive(1'b0, 12'h000); // Let the skip's write land before reset
    reset_dut();
    drive(1'b1, 12'h0C9);
    drive(1'b0, 12'h000);
    @(posedge clk_sys); #2;
    test_done();
end
endmodule
`default_nettype wire

// ### include/cds_map.svh
// Opcode patterns, field positions and reset values for the file-register op unit
`ifndef CDS_MAP_SVH
`define CDS_MAP_SVH

// ------------------------------------------------------------
// Opcode field layout (12-bit instruction word)
// ------------------------------------------------------------
`define OPC_W         12
`define OPC_HI        11
`define OPC_LO        6
`define DEST_BIT      5
`define FREG_HI       4
`define FREG_LO       0

// ------------------------------------------------------------
// Top six bits of each handled opcode
// ------------------------------------------------------------
`define OPC_COMPLEMENT 6'h09
`define OPC_DECREMENT  6'h03
`define OPC_DEC_SKIP   6'h0B

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ACC_RESET     8'h00
`define ZERO_RESET    1'b0

`endif

// ### include/cds_pkg.sv
// Types shared by the file-register op unit
package cds_pkg;
    typedef enum logic [1:0] {
        OP_NONE,
        OP_COMPLEMENT,
        OP_DECREMENT,
        OP_DEC_SKIP
    } file_op_t;

    typedef enum {
        ST_EXECUTE,
        ST_NO_OPERATION
    } exec_state_t;
endpackage
